/* File: design/ppsa_port.sv */
// Module: eight-pin port with sensing, event flags and alias window
//
// Strobed register access was decided locally.
`timescale 1ns/1ns

module ppsa_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire ppsa_pkg::ppsa_bus_t bus,
  output logic [7:0] rdata,
  // Pads
  input wire logic [7:0] pad_in,
  output ppsa_pkg::ppsa_pad_t pad,
  // Port event request
  output logic port_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] drive_enable;
  logic [7:0] drive_value;
  logic [7:0] flags;
  logic [7:0] ctrl [8];
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] level;
  logic [7:0] level_prev;
  logic [7:0] next_drive_enable;
  logic [7:0] next_drive_value;
  logic [7:0] next_flags;
  logic [7:0] next_ctrl [8];
  logic [7:0] next_level;
  logic [7:0] next_rdata;
  logic [7:0] buf_on;
  logic [7:0] hit;
  logic [7:0] wr_mask;

  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a >= ppsa_pkg::PAD_CONTROL_OFS) && (a <= ppsa_pkg::PAD_CONTROL_LAST);
  endfunction

  function automatic logic [2:0] ctrl_idx(input logic [7:0] a);
    logic [7:0] d;
    d = (a - ppsa_pkg::PAD_CONTROL_OFS) / ppsa_pkg::PAD_CONTROL_STEP;
    ctrl_idx = d[2:0];
  endfunction

  // ----------------------------------------------------------------
  // Sense decode
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ppsa_pkg::PIN_COUNT; i++) begin
      ppsa_pkg::ppsa_sense_t s;
      s = ppsa_pkg::ppsa_sense_t'(ctrl[i][ppsa_pkg::SENSE_LSB +: 3]);
      buf_on[i] = (s != ppsa_pkg::INPUT_BUFFER_OFF);
      case (s)
        ppsa_pkg::ANY_EDGE: hit[i] = level[i] ^ level_prev[i];
        ppsa_pkg::RISING_EDGE: hit[i] = level[i] & ~level_prev[i];
        ppsa_pkg::FALLING_EDGE: hit[i] = ~level[i] & level_prev[i];
        ppsa_pkg::LOW_LEVEL: hit[i] = ~level[i];
        default: hit[i] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_drive_enable = drive_enable;
    next_drive_value = drive_value;
    next_ctrl = ctrl;
    wr_mask = 8'h00;
    next_rdata = 8'h00;
    // Buffer off freezes the sampled level; inversion applied on input
    for (int i = 0; i < ppsa_pkg::PIN_COUNT; i++) begin
      next_level[i] = buf_on[i] ? (sync2[i] ^ ctrl[i][ppsa_pkg::POLARITY_SWAP_BIT])
                                : level[i];
    end
    if (bus.wr) begin
      if (bus.addr == ppsa_pkg::ALIAS_DRIVE_ENABLE_OFS) begin
        next_drive_enable = bus.wdata;
      end else if (bus.addr == ppsa_pkg::ALIAS_DRIVE_VALUE_OFS) begin
        next_drive_value = bus.wdata;
      end else if (bus.addr == ppsa_pkg::ALIAS_SAMPLED_LEVEL_OFS) begin
        next_drive_value = drive_value ^ bus.wdata;
      end else if (bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS ||
                   bus.addr == ppsa_pkg::PAD_EVENT_FLAGS_OFS) begin
        wr_mask = bus.wdata;
      end else if (is_ctrl(bus.addr)) begin
        next_ctrl[ctrl_idx(bus.addr)] = bus.wdata & ppsa_pkg::PAD_CONTROL_MASK;
      end
    end
    // Set wins over a same-cycle clear
    next_flags = (flags & ~wr_mask) | hit;
    if (bus.rd) begin
      if (bus.addr == ppsa_pkg::ALIAS_DRIVE_ENABLE_OFS) begin
        next_rdata = drive_enable;
      end else if (bus.addr == ppsa_pkg::ALIAS_DRIVE_VALUE_OFS) begin
        next_rdata = drive_value;
      end else if (bus.addr == ppsa_pkg::ALIAS_SAMPLED_LEVEL_OFS) begin
        next_rdata = level & buf_on;
      end else if (bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS ||
                   bus.addr == ppsa_pkg::PAD_EVENT_FLAGS_OFS) begin
        next_rdata = flags;
      end else if (is_ctrl(bus.addr)) begin
        next_rdata = ctrl[ctrl_idx(bus.addr)];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      drive_enable <= ppsa_pkg::REG_RESET;
      drive_value <= ppsa_pkg::REG_RESET;
      flags <= ppsa_pkg::REG_RESET;
      for (int i = 0; i < ppsa_pkg::PIN_COUNT; i++) begin
        ctrl[i] <= ppsa_pkg::REG_RESET;
      end
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      level <= 8'h00;
      level_prev <= 8'h00;
      rdata <= 8'h00;
      pad <= '0;
      port_irq <= 1'b0;
    end else begin
      drive_enable <= next_drive_enable;
      drive_value <= next_drive_value;
      flags <= next_flags;
      ctrl <= next_ctrl;
      sync1 <= pad_in;
      sync2 <= sync1;
      level <= next_level;
      level_prev <= level;
      rdata <= next_rdata;
      port_irq <= |next_flags;
      for (int i = 0; i < ppsa_pkg::PIN_COUNT; i++) begin
        pad.drive_out[i] <= next_drive_enable[i] &
                            (next_drive_value[i] ^ next_ctrl[i][ppsa_pkg::POLARITY_SWAP_BIT]);
        pad.pull_up[i] <= next_ctrl[i][ppsa_pkg::RESISTOR_PULL_HIGH_BIT];
      end
      pad.drive_oe <= next_drive_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_irq_follows_flags: assert property (@(posedge clk) disable iff (!rst_b)
    port_irq == (|flags))
    else $error("request does not follow flags");
  a_oe_follows_dir: assert property (@(posedge clk) disable iff (!rst_b)
    pad.drive_oe == drive_enable)
    else $error("output enable differs from direction");
  a_out_when_input: assert property (@(posedge clk) disable iff (!rst_b)
    (pad.drive_out & ~drive_enable) == 8'h00)
    else $error("input pin driven");
  a_toggle_write: assert property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::ALIAS_SAMPLED_LEVEL_OFS
    |=> drive_value == ($past(drive_value) ^ $past(bus.wdata)))
    else $error("level write did not toggle value");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS
    |=> (flags & $past(bus.wdata) & ~$past(hit)) == 8'h00)
    else $error("flag not cleared");
  a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
    (hit != 8'h00) |=> (flags & $past(hit)) == $past(hit))
    else $error("matching event not flagged");
  a_no_sense_off: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[0][2:0] == 3'h0 && !(bus.wr && bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS)
    && !(bus.wr && bus.addr == ppsa_pkg::PAD_EVENT_FLAGS_OFS)
    |=> flags[0] == $past(flags[0]))
    else $error("flag raised with sensing off");
  a_rise_detect: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[1][2:0] == 3'h2 && level[1] && !level_prev[1] |=> flags[1])
    else $error("rising edge missed");
  a_buffer_off_read: assert property (@(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == ppsa_pkg::ALIAS_SAMPLED_LEVEL_OFS && !buf_on[2]
    |=> !rdata[2])
    else $error("disabled pin readable");
  a_sync_delay: assert property (@(posedge clk) disable iff (!rst_b)
    buf_on[3] && !ctrl[3][7] && $stable(buf_on[3]) && $stable(ctrl[3])
    |=> level[3] == $past(sync2[3]))
    else $error("level not from synchroniser");

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_read_dir: assert property (@(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == ppsa_pkg::ALIAS_DRIVE_ENABLE_OFS
    |=> rdata == $past(drive_enable))
    else $error("direction read wrong");
  a_read_value: assert property (@(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == ppsa_pkg::ALIAS_DRIVE_VALUE_OFS
    |=> rdata == $past(drive_value))
    else $error("drive value read wrong");
  a_read_level: assert property (@(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == ppsa_pkg::ALIAS_SAMPLED_LEVEL_OFS
    |=> rdata == ($past(level) & $past(buf_on)))
    else $error("sampled level read wrong");
  a_read_alias_flags: assert property (@(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS
    |=> rdata == $past(flags))
    else $error("alias flags read wrong");
  a_read_reg_flags: assert property (@(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == ppsa_pkg::PAD_EVENT_FLAGS_OFS
    |=> rdata == $past(flags))
    else $error("regular flags read wrong");
  a_dir_write: assert property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::ALIAS_DRIVE_ENABLE_OFS
    |=> drive_enable == $past(bus.wdata))
    else $error("direction write lost");
  a_value_write: assert property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::ALIAS_DRIVE_VALUE_OFS
    |=> drive_value == $past(bus.wdata))
    else $error("drive value write lost");
  a_reg_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::PAD_EVENT_FLAGS_OFS
    |=> (flags & $past(bus.wdata) & ~$past(hit)) == 8'h00)
    else $error("regular flag not cleared");
  a_ctrl_unused_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[5] & 8'h70) == 8'h00)
    else $error("unused control bits set");

  // ----------------------------------------------------------------
  // Pad and sense checks
  // ----------------------------------------------------------------
  a_pull_follows: assert property (@(posedge clk) disable iff (!rst_b)
    pad.pull_up[0] == ctrl[0][ppsa_pkg::RESISTOR_PULL_HIGH_BIT])
    else $error("pull-up differs from control");
  a_invert_out: assert property (@(posedge clk) disable iff (!rst_b)
    pad.drive_out[0] == (drive_enable[0] &
    (drive_value[0] ^ ctrl[0][ppsa_pkg::POLARITY_SWAP_BIT])))
    else $error("output inversion wrong");
  a_invert_in: assert property (@(posedge clk) disable iff (!rst_b)
    buf_on[5] |=> level[5] == ($past(sync2[5]) ^ $past(ctrl[5][7])))
    else $error("input inversion wrong");
  a_fall_detect: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[1][2:0] == 3'h3 && !level[1] && level_prev[1] |=> flags[1])
    else $error("falling edge missed");
  a_any_detect: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[2][2:0] == 3'h1 && (level[2] != level_prev[2]) |=> flags[2])
    else $error("edge missed in any edge mode");
  a_low_detect: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[3][2:0] == 3'h5 && !level[3] |=> flags[3])
    else $error("low level missed");
  a_buffer_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !buf_on[4] |=> level[4] == $past(level[4]))
    else $error("disabled pin sampled");
  a_no_buffer_off: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[6][2:0] == 3'h4 && !(bus.wr && bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS)
    && !(bus.wr && bus.addr == ppsa_pkg::PAD_EVENT_FLAGS_OFS)
    |=> flags[6] == $past(flags[6]))
    else $error("flag raised with buffer off");
  a_low_no_clear: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[7][2:0] == 3'h5 && !level[7] && bus.wr
    && bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS |=> flags[7])
    else $error("clear beat a same-cycle set");

  c_edge_flag: cover property (@(posedge clk) disable iff (!rst_b) $rose(flags[0]));
  c_irq_drop: cover property (@(posedge clk) disable iff (!rst_b) $fell(port_irq));
  c_toggle: cover property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::ALIAS_SAMPLED_LEVEL_OFS);
  c_set_clear: cover property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == ppsa_pkg::ALIAS_EVENT_FLAGS_OFS && (hit & bus.wdata) != 8'h00);

endmodule

/* File: design/ppsa_pkg.sv */
// Package: register map, field layout and types of the pin port block
package ppsa_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ALIAS_DRIVE_ENABLE_OFS = 8'h00;
  localparam logic [7:0] ALIAS_DRIVE_VALUE_OFS = 8'h01;
  localparam logic [7:0] ALIAS_SAMPLED_LEVEL_OFS = 8'h02;
  localparam logic [7:0] ALIAS_EVENT_FLAGS_OFS = 8'h03;
  localparam logic [7:0] PAD_EVENT_FLAGS_OFS = 8'h09;
  localparam logic [7:0] PAD_CONTROL_OFS = 8'h10;
  localparam logic [7:0] PAD_CONTROL_STEP = 8'h01;
  localparam logic [7:0] PAD_CONTROL_LAST = 8'h17;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int POLARITY_SWAP_BIT = 7;
  localparam int RESISTOR_PULL_HIGH_BIT = 3;
  localparam int SENSE_LSB = 0;
  localparam logic [7:0] PAD_CONTROL_MASK = 8'h8F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int PIN_COUNT = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SENSE_OFF = 3'h0,
    ANY_EDGE = 3'h1,
    RISING_EDGE = 3'h2,
    FALLING_EDGE = 3'h3,
    INPUT_BUFFER_OFF = 3'h4,
    LOW_LEVEL = 3'h5
  } ppsa_sense_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ppsa_bus_t;

  typedef struct packed {
    logic [7:0] drive_out;
    logic [7:0] drive_oe;
    logic [7:0] pull_up;
  } ppsa_pad_t;

endpackage

/* File: test/ppsa_pads_model.sv */
// Model of the external circuits on the eight pads
`timescale 1ns/1ns
module ppsa_pads_model (
  // Clock
  input wire logic clk,
  // Device pad outputs
  input wire ppsa_pkg::ppsa_pad_t pad,
  // External drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved pad levels
  output logic [7:0] pad_in
);
  logic [7:0] last = 8'h00;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.drive_oe[i]) begin
        pad_in[i] = pad.drive_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad.pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last[i];
      end
    end
  end
  always @(posedge clk) last <= pad_in;
endmodule

/* File: test/test_ppsa_port.sv */
// Register-level testbench of the pin port block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_ppsa_port;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  ppsa_pkg::ppsa_bus_t bus = '0;
  logic [7:0] rdata;
  logic [7:0] pad_in;
  ppsa_pkg::ppsa_pad_t pad;
  logic port_irq;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'hFF;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  ppsa_port i_ppsa_port (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .pad_in(pad_in), .pad(pad), .port_irq(port_irq));
  ppsa_pads_model i_ppsa_pads_model (.clk(clk), .pad(pad), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(pad_in));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic ext(input logic [7:0] v);
    @(posedge clk);
    ext_val <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    for (int i = 0; i < 4; i++) rdc(8'(i), 8'h00);
    for (int i = 16; i < 24; i++) rdc(8'(i), 8'h00);
    $display("test reset done");
    // ------------------------------------------------------------
    // Direction, value, toggle, control fields
    // ------------------------------------------------------------
    wr(8'h00, 8'h0F);
    wr(8'h01, 8'h05);
    `CHK("oe", 8'h0F, pad.drive_oe)
    `CHK("out", 8'h05, pad.drive_out)
    wr(8'h02, 8'h03);
    `CHK("out", 8'h06, pad.drive_out)
    rdc(8'h01, 8'h06);
    wr(8'h10, 8'hFF);
    `CHK("out", 8'h07, pad.drive_out)
    `CHK("pull", 8'h01, pad.pull_up)
    rdc(8'h10, 8'h8F);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h00);
    `CHK("out", 8'h00, pad.drive_out)
    wr(8'h20, 8'hFF);
    rdc(8'h20, 8'h00);
    $display("test drive done");
    // ------------------------------------------------------------
    // Edge sensing, flags and request
    // ------------------------------------------------------------
    wr(8'h14, 8'h02);
    wr(8'h15, 8'h83);
    wr(8'h16, 8'h01);
    ext(8'hFF);
    rdc(8'h02, 8'hDF);
    rdc(8'h03, 8'h70);
    `CHK("irq", 1'b1, port_irq)
    wr(8'h09, 8'h30);
    rdc(8'h03, 8'h40);
    `CHK("irq", 1'b1, port_irq)
    wr(8'h03, 8'h40);
    `CHK("irq", 1'b0, port_irq)
    ext(8'h00);
    rdc(8'h09, 8'h40);
    wr(8'h03, 8'hFF);
    $display("test edge done");
    // ------------------------------------------------------------
    // Low level sense and input buffer off
    // ------------------------------------------------------------
    wr(8'h17, 8'h05);
    repeat (4) @(posedge clk);
    wr(8'h03, 8'h80);
    rdc(8'h03, 8'h80);
    wr(8'h17, 8'h04);
    wr(8'h03, 8'hFF);
    ext(8'h80);
    rdc(8'h02, 8'h20);
    rdc(8'h03, 8'h00);
    `CHK("irq", 1'b0, port_irq)
    $display("test level done");
    tally_and_finish;
  end
endmodule
